/* File: rtl/ddr_sram_port.sv */
/*
 Device side of a separate read/write port DDR static memory with burst of four.
 Assumes every pin input (clock pairs included) is asynchronous to clock_i and
 much slower than it, so the three-stage samplers see each link clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

// Function
// RQ1 - Valid flag high only while data driven
// RQ2 - Address captured on true clock rise
// RQ3 - Address ignored when neither select asserted
// RQ4 - Write data taken on both clock rises
// RQ5 - Data width 18 or 36 bits
// RQ6 - Read data follows output clocks, else input
// RQ7 - Read bus driven only for accepted reads
// RQ8 - Low write select starts write burst
// RQ9 - Low read select starts read burst
// RQ10 - Low byte enable writes its byte
// RQ11 - Echo clocks toggle even when bus idle
// RQ12 - No selects means no memory access
module ddr_sram_port
   import ddr_sram_port_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int DATA_W = DATA_W_MAX
)
(
   // System
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Link clocks from the controller
   input wire logic k_clk_i,
   input wire logic k_clk_n_i,
   input wire logic out_clk_i,
   input wire logic out_clk_n_i,
   // Requests from the controller
   input wire logic [ADDR_W-1:0] address_inputs_i,
   input wire logic read_sel_n_i,
   input wire logic write_sel_n_i,
   input wire logic [BYTE_N-1:0] byte_write_enable_n_i,
   input wire logic [DATA_W_MAX-1:0] write_data_in_i,
   // Read answer
   output logic [DATA_W_MAX-1:0] read_data_out_o,
   output logic read_data_oe_n_o,
   output logic read_data_valid_flag_o,
   output logic [1:0] echo_clock_pair_o
);

   // ************************************************************
   // Types and state
   // ************************************************************
   localparam int PIN_W = 4 + 2 + BYTE_N + DATA_W_MAX + ADDR_W;
   localparam int MEM_AW = ADDR_W + BEAT_W;
   localparam logic [DATA_W_MAX-1:0] DATA_MASK =
      (DATA_W >= DATA_W_MAX) ? {DATA_W_MAX{1'b1}} : {{(DATA_W_MAX-NARROW_W){1'b0}},
      {NARROW_W{1'b1}}};

   typedef struct packed {
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [PIN_W-1:0] s3;
      logic k_f;
      logic kn_f;
      logic c_f;
      logic cn_f;
      logic wr_act;
      logic [ADDR_W-1:0] wr_addr;
      logic [BEAT_W-1:0] wr_beat;
      logic wq_v;
      logic [ADDR_W-1:0] wq_addr;
      logic rd_act;
      logic [ADDR_W-1:0] rd_addr;
      logic [BEAT_W-1:0] rd_beat;
      logic rq_v;
      logic [ADDR_W-1:0] rq_addr;
      logic [1:0] f_cnt;
      logic [DATA_W_MAX-1:0] f_d0;
      logic [DATA_W_MAX-1:0] f_d1;
      logic [DATA_W_MAX-1:0] q;
      logic oe_n;
      logic valid;
      logic [1:0] cq;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic [DATA_W_MAX-1:0] mem [0:(1<<MEM_AW)-1];

   // ************************************************************
   // Sampled pins and link clock edges
   // ************************************************************
   logic s3_k, s3_kn, s3_c, s3_cn, s2_k, s2_kn, s2_c, s2_cn, s3_r_n, s3_w_n;
   logic [BYTE_N-1:0] s3_bw_n;
   logic [DATA_W_MAX-1:0] s3_d;
   logic [ADDR_W-1:0] s3_a;
   logic k_rise, kn_rise, c_rise, cn_rise, c_tie, out_edge;
   logic wr_strobe, rd_push, f_pop;
   logic [MEM_AW-1:0] wr_idx;
   logic [DATA_W_MAX-1:0] rd_word;

   assign {s3_k, s3_kn, s3_c, s3_cn, s3_r_n, s3_w_n, s3_bw_n, s3_d, s3_a} = st_reg.s3;
   assign {s2_k, s2_kn, s2_c, s2_cn} = st_reg.s2[PIN_W-1 -: 4];

   // A clock change counts only once stages two and three agree
   assign k_rise = (s2_k == s3_k) && s3_k && !st_reg.k_f;
   assign kn_rise = (s2_kn == s3_kn) && s3_kn && !st_reg.kn_f;
   assign c_rise = (s2_c == s3_c) && s3_c && !st_reg.c_f;
   assign cn_rise = (s2_cn == s3_cn) && s3_cn && !st_reg.cn_f;

   // Output clocks tied high fall back to the input clock pair
   assign c_tie = st_reg.c_f && st_reg.cn_f; // RQ6
   assign out_edge = c_tie ? (k_rise || kn_rise) : (c_rise || cn_rise); // RQ6

   // Even beats on true rise, odd beats on complement rise
   assign wr_strobe = st_reg.wr_act && (st_reg.wr_beat[0] ? kn_rise : k_rise); // RQ4
   assign wr_idx = {st_reg.wr_addr, st_reg.wr_beat};
   assign f_pop = out_edge && (st_reg.f_cnt != FIFO_EMPTY);
   // Fetch stalls while the buffer is full and nothing leaves
   assign rd_push = st_reg.rd_act && ((st_reg.f_cnt != FIFO_DEPTH) || f_pop);
   assign rd_word = mem[{st_reg.rd_addr, st_reg.rd_beat}] & DATA_MASK; // RQ5

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      st_next = st_reg;
      st_next.s1 = {k_clk_i, k_clk_n_i, out_clk_i, out_clk_n_i, read_sel_n_i,
         write_sel_n_i, byte_write_enable_n_i, write_data_in_i, address_inputs_i};
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      if (s2_k == s3_k) st_next.k_f = s3_k;
      if (s2_kn == s3_kn) st_next.kn_f = s3_kn;
      if (s2_c == s3_c) st_next.c_f = s3_c;
      if (s2_cn == s3_cn) st_next.cn_f = s3_cn;

      // Write burst: advance per beat, then take any queued command
      if (wr_strobe)
      begin
         st_next.wr_beat = st_reg.wr_beat + 2'h1;
         if (st_reg.wr_beat == BEAT_LAST)
         begin
            st_next.wr_act = st_reg.wq_v;
            st_next.wr_addr = st_reg.wq_addr;
            st_next.wr_beat = BEAT_FIRST;
            st_next.wq_v = 1'b0;
         end
      end
      // Selects and address only matter on a true clock rise
      if (k_rise && !s3_w_n) // RQ8
      begin
         if (!st_next.wr_act)
         begin
            st_next.wr_act = 1'b1; // RQ2
            st_next.wr_addr = s3_a;
            st_next.wr_beat = BEAT_FIRST;
         end
         else if (!st_next.wq_v)
         begin
            st_next.wq_v = 1'b1;
            st_next.wq_addr = s3_a;
         end
      end

      // Read burst: one beat per cycle into the buffer
      if (rd_push)
      begin
         st_next.rd_beat = st_reg.rd_beat + 2'h1;
         if (st_reg.rd_beat == BEAT_LAST)
         begin
            st_next.rd_act = st_reg.rq_v;
            st_next.rd_addr = st_reg.rq_addr;
            st_next.rd_beat = BEAT_FIRST;
            st_next.rq_v = 1'b0;
         end
      end
      if (k_rise && !s3_r_n) // RQ9
      begin
         if (!st_next.rd_act)
         begin
            st_next.rd_act = 1'b1; // RQ2
            st_next.rd_addr = s3_a;
            st_next.rd_beat = BEAT_FIRST;
         end
         else if (!st_next.rq_v)
         begin
            st_next.rq_v = 1'b1;
            st_next.rq_addr = s3_a;
         end
      end

      // Two-entry buffer, head in f_d0
      unique case ({rd_push, f_pop})
         2'b10:
         begin
            if (st_reg.f_cnt == FIFO_EMPTY) st_next.f_d0 = rd_word;
            else st_next.f_d1 = rd_word;
            st_next.f_cnt = st_reg.f_cnt + 2'h1;
         end
         2'b01:
         begin
            st_next.f_d0 = st_reg.f_d1;
            st_next.f_cnt = st_reg.f_cnt - 2'h1;
         end
         2'b11:
         begin
            st_next.f_d0 = (st_reg.f_cnt == 2'h1) ? rd_word : st_reg.f_d1;
            st_next.f_d1 = rd_word;
         end
         2'b00: ;
      endcase

      // Each output clock rise launches a beat or releases the bus
      if (out_edge)
      begin
         st_next.q = f_pop ? st_reg.f_d0 : '0; // RQ7
         st_next.oe_n = !f_pop; // RQ7
         st_next.valid = f_pop; // RQ1
      end
      // Echo clock never pauses for an idle bus
      st_next.cq = c_tie ? {st_reg.k_f, !st_reg.k_f} : {st_reg.c_f, !st_reg.c_f}; // RQ11

      if (sys_rst_i)
      begin
         st_next = '0;
         st_next.oe_n = OE_N_RESET;
         st_next.valid = VALID_RESET;
         st_next.cq = ECHO_RESET;
      end
   end

   always_ff @(posedge clock_i)
   begin
      st_reg <= st_next;
   end

   // ************************************************************
   // Memory array
   // ************************************************************
   // Per-byte masked write; lanes beyond the data width are ignored
   always_ff @(posedge clock_i)
   begin
      if (wr_strobe && !sys_rst_i)
      begin
         for (int b = 0; b < BYTE_N; b++)
         begin
            if (!s3_bw_n[b] && (b * BYTE_W < DATA_W)) // RQ10
               mem[wr_idx][b*BYTE_W +: BYTE_W] <= s3_d[b*BYTE_W +: BYTE_W]; // RQ4
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign read_data_out_o = st_reg.q;
   assign read_data_oe_n_o = st_reg.oe_n;
   assign read_data_valid_flag_o = st_reg.valid;
   assign echo_clock_pair_o = st_reg.cq;

   // ************************************************************
   // Checks
   // ************************************************************
   AST_VALID_WITH_DRIVE: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ1
      read_data_valid_flag_o == !read_data_oe_n_o)
      else $error("valid flag and bus drive disagree");
   AST_DRIVE_NEEDS_DATA: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ7
      $fell(read_data_oe_n_o) |-> $past(st_reg.f_cnt) != FIFO_EMPTY)
      else $error("bus driven with empty buffer");
   AST_READ_CAPTURE: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ9
      (k_rise && !s3_r_n && !st_reg.rd_act) |=> st_reg.rd_act && st_reg.rd_addr == $past(s3_a))
      else $error("read address not captured");
   AST_WRITE_CAPTURE: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ8
      (k_rise && !s3_w_n && !st_reg.wr_act) |=> st_reg.wr_act && st_reg.wr_beat == BEAT_FIRST
      && st_reg.wr_addr == $past(s3_a))
      else $error("write address not captured");
   AST_NO_SELECT: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ3
      (!st_reg.rd_act && !(k_rise && !s3_r_n)) |=> !st_reg.rd_act)
      else $error("read started without select");
   AST_IDLE_NO_WRITE: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ12
      (k_rise && s3_w_n && s3_r_n && !st_reg.wr_act) |=> !st_reg.wr_act)
      else $error("memory written while idle");
   AST_BEAT_EDGES: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ4
      wr_strobe |-> (k_rise || kn_rise))
      else $error("write beat off a clock rise");
   AST_NARROW_ZERO: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ5
      (read_data_out_o & ~DATA_MASK) == '0)
      else $error("unused data bits driven");
   AST_OUT_ON_EDGE: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ6
      !out_edge |=> $stable(read_data_out_o) && $stable(read_data_valid_flag_o))
      else $error("read data moved off an output clock edge");
   AST_ECHO_FOLLOWS: assert property (@(posedge clock_i) disable iff (sys_rst_i) // RQ11
      ($rose(st_reg.k_f) && c_tie) |=> ##1 echo_clock_pair_o == 2'b10)
      else $error("echo clock stopped");

endmodule : ddr_sram_port

`default_nettype wire

/* File: rtl/ddr_sram_port_pkg.sv */
/*
 Constants shared by the separate-port double data rate memory port:
 widths, burst shape and reset values.
 Assumes a single system clock that samples every pin of the link.
*/
`default_nettype none

package ddr_sram_port_pkg;
   // Data path and byte lanes
   localparam int DATA_W_MAX = 36;
   localparam int BYTE_W = 9;
   localparam int BYTE_N = 4;
   localparam int NARROW_W = 18;
   // Burst of four beats per address
   localparam int BEAT_W = 2;
   localparam logic [1:0] BEAT_FIRST = 2'h0;
   localparam logic [1:0] BEAT_LAST = 2'h3;
   // Default burst address width of the widest part
   localparam int ADDR_W_DEF = 18;
   // Two-entry output buffer
   localparam logic [1:0] FIFO_DEPTH = 2'h2;
   localparam logic [1:0] FIFO_EMPTY = 2'h0;
   // Values after reset
   localparam logic OE_N_RESET = 1'b1;
   localparam logic VALID_RESET = 1'b0;
   // Echo pair after reset: true low, complement high
   localparam logic [1:0] ECHO_RESET = 2'h1;
endpackage : ddr_sram_port_pkg

`default_nettype wire

/* File: sim/ddr_ctrl_model.sv */
/*
 Memory controller model: free-running K pair, commands and DDR write beats.
 Assumes clock_i is the bench clock; K period is eight clock_i cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module ddr_ctrl_model
#(
   parameter int AW = 4
)
(
   // Bench
   input wire logic clock_i,
   input wire logic oc_mode_i,
   // Link pins
   output var logic k_clk_o,
   output logic k_clk_n_o,
   output logic out_clk_o,
   output logic out_clk_n_o,
   output var logic [AW-1:0] addr_o,
   output var logic read_sel_n_o,
   output var logic write_sel_n_o,
   output var logic [3:0] bw_n_o,
   output var logic [35:0] wdata_o
);
   logic [1:0] ph_reg;

   initial
   begin
      ph_reg = 2'h0;
      k_clk_o = 1'b0;
      addr_o = '0;
      read_sel_n_o = 1'b1;
      write_sel_n_o = 1'b1;
      bw_n_o = 4'hF;
      wdata_o = 36'h0;
   end

   // K flips every four cycles and runs free, as a clock input does
   always @(posedge clock_i)
   begin
      ph_reg <= ph_reg + 2'h1;
      if (ph_reg == 2'h3)
         k_clk_o <= ~k_clk_o;
   end
   assign k_clk_n_o = ~k_clk_o;
   // C pair held high selects K timing for read data
   assign out_clk_o = oc_mode_i ? k_clk_o : 1'b1;
   assign out_clk_n_o = oc_mode_i ? ~k_clk_o : 1'b1;

   // Return at the edge where K turns to lvl; checked off-edge to avoid races
   task automatic k_edge(input logic lvl);
      do @(negedge clock_i); while (!(ph_reg == 2'h3 && k_clk_o != lvl));
      @(posedge clock_i);
   endtask : k_edge

   // Command before a K rise, then beats for K, K#, K, K#; released lines invert
   // Data moves a quarter K period after an edge, so it never races a capture edge
   task automatic write_burst(input logic [AW-1:0] a, input logic [143:0] d,
                              input logic [15:0] m);
      k_edge(1'b0);
      write_sel_n_o <= 1'b0;
      addr_o <= a;
      for (int i = 0; i < 4; i++)
      begin
         k_edge(i[0]);
         repeat (2) @(posedge clock_i);
         if (i == 0)
         begin
            write_sel_n_o <= 1'b1;
            addr_o <= ~a;
         end
         wdata_o <= d[36*i+:36];
         bw_n_o <= m[4*i+:4];
      end
      k_edge(1'b0);
      repeat (2) @(posedge clock_i);
      wdata_o <= ~wdata_o;
      bw_n_o <= ~bw_n_o;
   endtask : write_burst

   task automatic read_burst(input logic [AW-1:0] a);
      k_edge(1'b0);
      read_sel_n_o <= 1'b0;
      addr_o <= a;
      k_edge(1'b0);
      read_sel_n_o <= 1'b1;
      addr_o <= ~a;
   endtask : read_burst
endmodule : ddr_ctrl_model

`default_nettype wire

/* File: sim/ddr_sram_port_tb_top.sv */
/*
 Bench for the DDR memory port: writes, masked writes, reads in both timings.
 Assumes the controller model in ddr_ctrl_model drives every link pin.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin fail_count++; \
   $display("BAD %s exp %h got %h", nm, ex, gt); end end

module ddr_sram_port_tb_top;
   import ddr_sram_port_pkg::*;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic oc_mode = 1'b0;
   wire logic k, kn, c, cn, rs_n, ws_n;
   wire logic [3:0] a;
   wire logic [3:0] bw_n;
   wire logic [35:0] wd;
   logic [35:0] q;
   logic [35:0] q18;
   logic oe_n, valid;
   logic [1:0] echo;
   int fail_count = 0;
   int compares = 0;
   localparam logic [143:0] DA = {36'h9_1111_1110, 36'hA_2222_2221,
                                  36'hB_4444_4442, 36'hC_8888_8884};
   localparam logic [143:0] DB = {36'h1_2345_6789, 36'hF_EDCB_A987,
                                  36'h5_5555_5555, 36'h6_6666_6666};
   localparam logic [15:0] MB = {4'h5, 4'hF, 4'h0, 4'hE};

   always #20 clock_i = ~clock_i;

   ddr_ctrl_model #(.AW(4)) ddr_ctrl_model_inst (.clock_i(clock_i), .oc_mode_i(oc_mode),
      .k_clk_o(k), .k_clk_n_o(kn), .out_clk_o(c), .out_clk_n_o(cn), .addr_o(a),
      .read_sel_n_o(rs_n), .write_sel_n_o(ws_n), .bw_n_o(bw_n), .wdata_o(wd));

   ddr_sram_port #(.ADDR_W(4), .DATA_W(36)) ddr_sram_port_inst (.clock_i(clock_i),
      .sys_rst_i(sys_rst_i), .k_clk_i(k), .k_clk_n_i(kn), .out_clk_i(c),
      .out_clk_n_i(cn), .address_inputs_i(a), .read_sel_n_i(rs_n),
      .write_sel_n_i(ws_n), .byte_write_enable_n_i(bw_n), .write_data_in_i(wd),
      .read_data_out_o(q), .read_data_oe_n_o(oe_n), .read_data_valid_flag_o(valid),
      .echo_clock_pair_o(echo));

   // Narrow build on the same pins: only the low two lanes may carry data
   ddr_sram_port #(.ADDR_W(4), .DATA_W(18)) ddr_sram_port_narrow_inst (.clock_i(clock_i),
      .sys_rst_i(sys_rst_i), .k_clk_i(k), .k_clk_n_i(kn), .out_clk_i(c),
      .out_clk_n_i(cn), .address_inputs_i(a), .read_sel_n_i(rs_n),
      .write_sel_n_i(ws_n), .byte_write_enable_n_i(bw_n), .write_data_in_i(wd),
      .read_data_out_o(q18), .read_data_oe_n_o(), .read_data_valid_flag_o(),
      .echo_clock_pair_o());

   // Flag and bus drive must agree on every cycle
   always @(negedge clock_i)
      if (!sys_rst_i)
         `CHK("valid_vs_oe", ~oe_n, valid)

   task automatic complete_run();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                         input logic [3:0] m);
      for (int b = 0; b < 4; b++)
         if (!m[b])
            o[9*b+:9] = n[9*b+:9];
      return o;
   endfunction : merge

   // Read one burst; each new word while valid is a beat, all 36 bits compared
   task automatic read_check(input logic [3:0] ad, input logic [143:0] ex);
      logic [35:0] got[$];
      logic [35:0] got18[$];
      logic pv;
      logic [35:0] pd;
      int n;
      pv = 1'b0;
      pd = 36'h0;
      n = 0;
      fork
         ddr_ctrl_model_inst.read_burst(ad);
         while (n < 300 && !(got.size() == 4 && !valid))
         begin
            @(negedge clock_i);
            n++;
            if (valid && (!pv || q !== pd))
            begin
               got.push_back(q);
               got18.push_back(q18);
            end
            if (!valid)
               `CHK("q_idle", 36'h0, q)
            pv = valid;
            pd = q;
         end
      join
      if (n >= 300)
      begin
         fail_count++;
         complete_run();
      end
      `CHK("beats", 4, got.size())
      for (int i = 0; i < got.size() && i < 4; i++)
      begin
         `CHK("beat", ex[36*i+:36], got[i])
         `CHK("beat_narrow", ex[36*i+:36] & 36'h0_0003_FFFF, got18[i])
      end
   endtask : read_check

   task automatic t_mask();
      logic [143:0] ex;
      ddr_ctrl_model_inst.write_burst(4'h3, DB, MB);
      for (int i = 0; i < 4; i++)
         ex[36*i+:36] = merge(DA[36*i+:36], DB[36*i+:36], MB[4*i+:4]);
      read_check(4'h3, ex);
   endtask : t_mask

   // Idle span: echo keeps toggling, contents untouched
   task automatic t_idle();
      int t;
      logic [143:0] ex;
      logic pe;
      t = 0;
      pe = echo[1];
      for (int i = 0; i < 64; i++)
      begin
         @(negedge clock_i);
         `CHK("echo_pair", ~echo[0], echo[1])
         if (echo[1] !== pe)
            t++;
         pe = echo[1];
      end
      `CHK("echo_toggle", 1'b1, t >= 6)
      for (int i = 0; i < 4; i++)
         ex[36*i+:36] = merge(DA[36*i+:36], DB[36*i+:36], MB[4*i+:4]);
      read_check(4'h3, ex);
      read_check(4'hC, DA);
   endtask : t_idle

   initial
   begin
      repeat (12) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      repeat (4) @(negedge clock_i);
      `CHK("oe_n_rst", OE_N_RESET, oe_n)
      `CHK("valid_rst", VALID_RESET, valid)
      ddr_ctrl_model_inst.write_burst(4'h3, DA, 16'h0);
      ddr_ctrl_model_inst.write_burst(4'hC, DA, 16'h0);
      read_check(4'h3, DA);
      t_mask();
      @(posedge clock_i);
      oc_mode <= 1'b1;
      t_idle();
      complete_run();
   end
endmodule : ddr_sram_port_tb_top

`default_nettype wire
